// [wtc_regs.vh]
`ifndef WTC_REGS_VH
`define WTC_REGS_VH

// Register addresses
`define WTC_ADDR_COMPARE 32'h0FFFF8B1
`define WTC_ADDR_MODE 32'h0FFFF8B0
`define WTC_ADDR_WATCH_MODE 32'hFFFFF680
`define WTC_ADDR_STATUS 32'h0FFFF8B2

// Reset values
`define WTC_RST_COMPARE 8'h00
`define WTC_RST_MODE 8'h00
`define WTC_RST_WATCH_MODE 8'h00

// prescaler_mode fields
`define WTC_MODE_DIV_LO 0
`define WTC_MODE_DIV_HI 1
`define WTC_MODE_SUPPLY_EN 7
`define WTC_MODE_MASK 8'h83

// watch_operation_mode fields
`define WTC_WTM_RUN 0
`define WTC_WTM_TICK_RUN 1
`define WTC_WTM_TSEL_LO 2
`define WTC_WTM_TSEL_HI 3
`define WTC_WTM_ISEL_LO 4
`define WTC_WTM_ISEL_HI 6
`define WTC_WTM_CLK_SEL 7

// Timing: lowest tap and 5-bit counter divide as powers of two of the watch clock, and prescaler width
`define WTC_TAP_LOW 4
`define WTC_TAP_FIVE_BIT_DIV 9
`define WTC_PRE_BITS 11

`endif

// [wtc_brg.v]
`timescale 1ns/10ps
`default_nettype none

// Count clock generator: source prescaler plus compare divider.
// Produces single-cycle enables instead of derived clocks.
module wtc_brg
(
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Control
    input wire supply_en,
    input wire [1:0] div_sel,
    input wire [7:0] compare,
    // Result
    output reg count_tick_r
);

    reg [2:0] pre_r;
    reg [7:0] cnt_r;
    reg half_r;
    reg src_tick;
    wire [7:0] last_val;

    // A compare value of zero wraps to 8'hFF, giving N of 256
    assign last_val = compare - 8'h01;

    // Clock control: main clock only reaches the divider while supplied
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            pre_r <= 3'h0;
        else if (!supply_en)
            pre_r <= 3'h0;
        else
            pre_r <= pre_r + 3'h1;
    end

    always @*
    begin
        case (div_sel)
            2'h0: src_tick = supply_en;
            2'h1: src_tick = supply_en & pre_r[0];
            2'h2: src_tick = supply_en & (&pre_r[1:0]);
            default: src_tick = supply_en & (&pre_r[2:0]);
        endcase
    end

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= 8'h00;
            half_r <= 1'b0;
            count_tick_r <= 1'b0;
        end
        else if (!supply_en)
        begin
            cnt_r <= 8'h00;
            half_r <= 1'b0;
            count_tick_r <= 1'b0;
        end
        else
        begin
            count_tick_r <= 1'b0;
            if (src_tick)
            begin
                if (cnt_r == last_val)
                begin
                    cnt_r <= 8'h00;
                    half_r <= ~half_r;
                    // Rising half of the count clock: one tick per 2N
                    count_tick_r <= ~half_r;
                end
                else
                    cnt_r <= cnt_r + 8'h01;
            end
        end
    end

endmodule
`default_nettype wire

// [wtc_top.v]
//
// Contract
// - Watch tick every 0.5 or 0.25 s
// - Interval tick runs alongside watch tick
// - Gate main clock toward watch logic
// - Prescaler gives half, quarter, eighth rates
// - 8-bit counter counts selected source clock
// - Select derived count clock or subclock
// - 11-bit prescaler taps 2^4 to 2^11
// - 5-bit counter counts fw or fw/2^9
// - Watch period 2^4, 2^5, 2^13, 2^14
// - Interval period any tap 2^4..2^11
// - Reset clears mode and compare registers
// - Mode bit-accessible, compare byte only
// - Count clock equals source over 2N
// - Run bits start; run clear clears counters
// - Derived clock only while supply enabled
// - Two bits select divide value m
//
`timescale 1ns/10ps
`default_nettype none
`include "wtc_regs.vh"

module wtc_top
(
    // Clock and reset
    input wire mclk,
    input wire arst_n,
    // Subclock pin
    input wire sub_oscillator_clock,
    // Register port
    input wire [31:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_r,
    // Interrupt requests
    output reg watch_tick_irq_r,
    output reg interval_tick_irq_r
);

    reg rst_s1_r;
    reg rst_n_r;
    reg [7:0] prescaler_compare_r;
    reg [7:0] prescaler_mode_r;
    reg [7:0] watch_operation_mode_r;
    reg sub_s1_r;
    reg sub_s2_r;
    reg sub_s3_r;
    reg [10:0] pre_r;
    reg [4:0] tick_cnt_r;
    reg [7:0] rdata_nxt;
    reg five_tick;
    reg watch_hit;
    wire count_tick;
    wire sub_tick;
    wire fw_tick;
    wire run;
    wire tick_run;
    wire [1:0] div_sel;
    wire [1:0] watch_sel;
    wire [2:0] ival_sel;
    wire [7:0] tap_tick;
    wire [10:0] pre_inc;

    // Reset release through two flops
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    // Register writes; byte-wide only, which satisfies both access widths
    always @(posedge mclk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            prescaler_compare_r <= `WTC_RST_COMPARE;
            prescaler_mode_r <= `WTC_RST_MODE;
            watch_operation_mode_r <= `WTC_RST_WATCH_MODE;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `WTC_ADDR_COMPARE)
                prescaler_compare_r <= reg_wdata;
            if (reg_addr == `WTC_ADDR_MODE)
                prescaler_mode_r <= reg_wdata & `WTC_MODE_MASK;
            if (reg_addr == `WTC_ADDR_WATCH_MODE)
                watch_operation_mode_r <= reg_wdata;
        end
    end

    // Read data stand only in the cycle after the strobe
    always @*
    begin
        rdata_nxt = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                `WTC_ADDR_COMPARE: rdata_nxt = prescaler_compare_r;
                `WTC_ADDR_MODE: rdata_nxt = prescaler_mode_r;
                `WTC_ADDR_WATCH_MODE: rdata_nxt = watch_operation_mode_r;
                `WTC_ADDR_STATUS: rdata_nxt = {2'h0, run & tick_run, tick_cnt_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always @(posedge mclk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            reg_rdata_r <= 8'h00;
        else
            reg_rdata_r <= rdata_nxt;
    end

    assign div_sel = {prescaler_mode_r[`WTC_MODE_DIV_HI], prescaler_mode_r[`WTC_MODE_DIV_LO]};
    assign run = watch_operation_mode_r[`WTC_WTM_RUN];
    assign tick_run = watch_operation_mode_r[`WTC_WTM_TICK_RUN];
    assign watch_sel = watch_operation_mode_r[`WTC_WTM_TSEL_HI:`WTC_WTM_TSEL_LO];
    assign ival_sel = watch_operation_mode_r[`WTC_WTM_ISEL_HI:`WTC_WTM_ISEL_LO];

    // Divide settings are assumed static while running; no shadowing is done
    wtc_brg u_brg
    (
        .mclk(mclk),
        .rst_n(rst_n_r),
        .supply_en(prescaler_mode_r[`WTC_MODE_SUPPLY_EN]),
        .div_sel(div_sel),
        .compare(prescaler_compare_r),
        .count_tick_r(count_tick)
    );

    // Subclock is far slower than mclk; sample and take its rising edge
    always @(posedge mclk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            sub_s1_r <= 1'b0;
            sub_s2_r <= 1'b0;
            sub_s3_r <= 1'b0;
        end
        else
        begin
            sub_s1_r <= sub_oscillator_clock;
            sub_s2_r <= sub_s1_r;
            sub_s3_r <= sub_s2_r;
        end
    end

    assign sub_tick = sub_s2_r & ~sub_s3_r;

    // Watch clock source
    assign fw_tick = watch_operation_mode_r[`WTC_WTM_CLK_SEL] ? count_tick : sub_tick;

    // 11-bit prescaler; cleared while the run bit is low
    assign pre_inc = pre_r + 11'h001;

    always @(posedge mclk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            pre_r <= 11'h000;
        else if (!run)
            pre_r <= 11'h000;
        else if (fw_tick)
            pre_r <= pre_inc;
    end

    // Tap k fires when the low k+4 prescaler bits are about to wrap
    genvar k;
    generate
        for (k = 0; k < 8; k = k + 1)
        begin : g_tap
            assign tap_tick[k] = run & fw_tick & (&pre_r[k + 3:0]);
        end
    endgenerate

    // 5-bit counter input: fw for short periods, fw/2^9 for long ones
    always @*
    begin
        if (watch_sel[1])
            five_tick = run & fw_tick;
        else
            five_tick = run & fw_tick & (&pre_r[`WTC_TAP_FIVE_BIT_DIV - 1:0]);
    end

    // Period select: 00 = 2^14, 01 = 2^13, 10 = 2^5, 11 = 2^4
    always @*
    begin
        case (watch_sel)
            2'h0: watch_hit = &tick_cnt_r[4:0];
            2'h1: watch_hit = &tick_cnt_r[3:0];
            2'h2: watch_hit = &tick_cnt_r[4:0];
            default: watch_hit = &tick_cnt_r[3:0];
        endcase
    end

    // Clearing only the tick-run bit lets software trim the watch phase
    // without disturbing the interval timer.
    always @(posedge mclk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            tick_cnt_r <= 5'h00;
        else if (!run || !tick_run)
            tick_cnt_r <= 5'h00;
        else if (five_tick)
            tick_cnt_r <= tick_cnt_r + 5'h01;
    end

    // Interrupt pulses, one mclk cycle each
    always @(posedge mclk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            watch_tick_irq_r <= 1'b0;
            interval_tick_irq_r <= 1'b0;
        end
        else
        begin
            watch_tick_irq_r <= run & tick_run & five_tick & watch_hit;
            interval_tick_irq_r <= tap_tick[ival_sel];
        end
    end

endmodule
`default_nettype wire

// [wtc_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
`include "wtc_regs.vh"
module wtc_monitor
(
    // Clock and reset
    input wire mclk,
    input wire arst_n,
    // Register port
    input wire [31:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata_r,
    // Interrupts
    input wire watch_tick_irq_r,
    input wire interval_tick_irq_r
);
    reg [7:0] cmp_r, mode_r, wtm_r;
    reg [3:0] idle_r;
    wire a_c = reg_addr == `WTC_ADDR_COMPARE;
    wire a_m = reg_addr == `WTC_ADDR_MODE;
    wire a_w = reg_addr == `WTC_ADDR_WATCH_MODE;
    wire unmap = !a_c && !a_m && !a_w && reg_addr != `WTC_ADDR_STATUS;
    always @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cmp_r <= 8'h00;
            mode_r <= 8'h00;
            wtm_r <= 8'h00;
            idle_r <= 4'h0;
        end
        else
        begin
            if (reg_wr && a_c)
                cmp_r <= reg_wdata;
            if (reg_wr && a_m)
                mode_r <= reg_wdata & `WTC_MODE_MASK;
            if (reg_wr && a_w)
                wtm_r <= reg_wdata;
            // Stopped, or main path picked with its supply gated off
            if (!wtm_r[0] || (wtm_r[7] && !mode_r[7]))
                idle_r <= (idle_r == 4'h8) ? idle_r : idle_r + 4'h1;
            else
                idle_r <= 4'h0;
        end
    end
    rd_slot_a: assert property (@(posedge mclk) disable iff (!arst_n)
        !$past(reg_rd) |-> reg_rdata_r == 8'h00) else $error("data outside read slot");
    cmp_read_a: assert property (@(posedge mclk) disable iff (!arst_n)
        reg_rd && a_c |=> reg_rdata_r == $past(cmp_r)) else $error("compare readback");
    mode_read_a: assert property (@(posedge mclk) disable iff (!arst_n)
        reg_rd && a_m |=> reg_rdata_r == $past(mode_r)) else $error("mode readback");
    wtm_read_a: assert property (@(posedge mclk) disable iff (!arst_n)
        reg_rd && a_w |=> reg_rdata_r == $past(wtm_r)) else $error("watch mode readback");
    unmap_read_a: assert property (@(posedge mclk) disable iff (!arst_n)
        reg_rd && unmap |=> reg_rdata_r == 8'h00) else $error("unmapped read not zero");
    watch_pulse_a: assert property (@(posedge mclk) disable iff (!arst_n)
        watch_tick_irq_r |=> !watch_tick_irq_r [*8]) else $error("watch tick too close");
    intv_pulse_a: assert property (@(posedge mclk) disable iff (!arst_n)
        interval_tick_irq_r |=> !interval_tick_irq_r [*8]) else $error("interval too close");
    stop_quiet_a: assert property (@(posedge mclk) disable iff (!arst_n)
        idle_r == 4'h8 |-> !watch_tick_irq_r && !interval_tick_irq_r)
        else $error("tick while stopped");
endmodule
bind wtc_top wtc_monitor mon (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_r, .watch_tick_irq_r, .interval_tick_irq_r);
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "wtc_regs.vh"
module tb_top;
    reg mclk = 1'b0;
    reg arst_n = 1'b0;
    reg sub_clk = 1'b0;
    reg [31:0] addr = 32'h0;
    reg [7:0] wd = 8'h00;
    reg wr = 1'b0;
    reg rd = 1'b0;
    wire [7:0] rdata;
    wire w_irq;
    wire i_irq;
    integer miscompares = 0;
    integer check_count = 0;
    integer cyc = 0;
    integer i;
    integer g;
    wtc_top dut
    (
        .mclk(mclk),
        .arst_n(arst_n),
        .sub_oscillator_clock(sub_clk),
        .reg_addr(addr),
        .reg_wdata(wd),
        .reg_wr(wr),
        .reg_rd(rd),
        .reg_rdata_r(rdata),
        .watch_tick_irq_r(w_irq),
        .interval_tick_irq_r(i_irq)
    );
    initial forever #4 mclk = ~mclk;
    // 64 ns subclock stays well under the sampler's mclk/4 limit
    initial forever #32 sub_clk = ~sub_clk;
    task summarize;
    begin
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            miscompares = miscompares + 1;
            $display("MISMATCH t=%0t seen %0h exp %0h", $time, seen, exp);
        end
    end
    endtask
    task wreg(input logic [31:0] a, input logic [7:0] d);
    begin
        @(posedge mclk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    end
    endtask
    task rreg(input logic [31:0] a, input logic [7:0] e);
    begin
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        chk(rdata, e);
    end
    endtask
    // Cycles until the chosen tick shows, bounded
    task gap(input k, output integer c);
    begin
        c = 0;
        while ((k ? w_irq : i_irq) !== 1'b1 && c < 70000)
        begin
            @(negedge mclk);
            c = c + 1;
        end
    end
    endtask
    task per(input k, output integer p);
    begin
        gap(k, p);
        @(negedge mclk);
        gap(k, p);
        p = p + 1;
    end
    endtask
    task quiet;
        integer n;
    begin
        n = 0;
        repeat (8) @(negedge mclk);
        repeat (300)
        begin
            @(negedge mclk);
            if (w_irq !== 1'b0 || i_irq !== 1'b0)
                n = n + 1;
        end
        chk(n, 0);
    end
    endtask
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 100000)
        begin
            miscompares = miscompares + 1;
            summarize;
        end
    end
    initial
    begin
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rreg(`WTC_ADDR_COMPARE, 8'h00);
        rreg(`WTC_ADDR_MODE, 8'h00);
        wreg(`WTC_ADDR_COMPARE, 8'hA5);
        rreg(`WTC_ADDR_COMPARE, 8'hA5);
        wreg(`WTC_ADDR_MODE, 8'hFF);
        rreg(`WTC_ADDR_MODE, 8'h83);
        wreg(32'h0FFFF8B3, 8'h5A);
        rreg(32'h0FFFF8B3, 8'h00);
        rreg(`WTC_ADDR_STATUS, 8'h00);
        $display("test registers done");
        wreg(`WTC_ADDR_MODE, 8'h00);
        wreg(`WTC_ADDR_COMPARE, 8'h01);
        wreg(`WTC_ADDR_MODE, 8'h80);
        for (i = 0; i < 8; i = i + 1)
        begin
            wreg(`WTC_ADDR_WATCH_MODE, 8'h00);
            wreg(`WTC_ADDR_WATCH_MODE, {1'b1, i[2:0], 4'h1});
            per(1'b0, g);
            chk(g, 2 << (4 + i));
        end
        quiet;
        $display("test interval taps done");
        for (i = 0; i < 5; i = i + 1)
        begin
            wreg(`WTC_ADDR_WATCH_MODE, 8'h00);
            wreg(`WTC_ADDR_MODE, 8'h00);
            wreg(`WTC_ADDR_COMPARE, (i < 4) ? 8'h03 : 8'h00);
            wreg(`WTC_ADDR_MODE, {6'h00, i[1:0]});
            wreg(`WTC_ADDR_MODE, {6'h20, i[1:0]});
            wreg(`WTC_ADDR_WATCH_MODE, {5'h11, ~i[0], 2'h3});
            per(1'b1, g);
            chk(g, ((i[0] ? 32 : 16) * 2 * ((i < 4) ? 3 : 256)) << i[1:0]);
        end
        $display("test source divide done");
        wreg(`WTC_ADDR_WATCH_MODE, 8'h00);
        wreg(`WTC_ADDR_MODE, 8'h00);
        wreg(`WTC_ADDR_COMPARE, 8'h01);
        wreg(`WTC_ADDR_MODE, 8'h80);
        for (i = 0; i < 2; i = i + 1)
        begin
            wreg(`WTC_ADDR_WATCH_MODE, 8'h00);
            wreg(`WTC_ADDR_WATCH_MODE, {5'h10, i[0], 2'h3});
            gap(1'b1, g);
            chk(g > (32760 >> i) && g < (32776 >> i), 1);
        end
        $display("test long periods done");
        wreg(`WTC_ADDR_MODE, 8'h00);
        quiet;
        wreg(`WTC_ADDR_WATCH_MODE, 8'h00);
        wreg(`WTC_ADDR_WATCH_MODE, 8'h0F);
        per(1'b1, g);
        chk(g, 128);
        wreg(`WTC_ADDR_WATCH_MODE, 8'h0E);
        quiet;
        rreg(`WTC_ADDR_STATUS, 8'h00);
        $display("test gating done");
        summarize;
    end
endmodule
`default_nettype wire
